// ==== verilog/lpc_irq_pkg.sv ====
// Behaviour
// R1 - claim and complete IO and memory cycles
// R2 - answer 8-bit firmware, DMA cycles; request DMA
// R3 - all units reachable except board glue
// R4 - map, enable, polarity stage per interrupt source
// R5 - drive each number only in its slot
// R6 - never two sources on one number
// R7 - changed source level sent in its slot
// R8 - unchanged sources resend last level every frame
`default_nettype none
package lpc_irq_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // lpc field codes
   localparam logic [3:0]  START_MEM_IO = 4'h0;
   localparam logic [3:0]  START_FW_RD  = 4'hd;
   localparam logic [3:0]  START_FW_WR  = 4'he;
   localparam logic [3:0]  SYNC_READY   = 4'h0;
   localparam logic [3:0]  SYNC_LWAIT   = 4'h6;
   localparam logic [3:0]  LAD_IDLE     = 4'hf;
   localparam logic [3:0]  NIB_IO       = 4'h3;
   localparam logic [3:0]  NIB_MEM      = 4'h7;
   localparam logic [3:0]  NIB_ONE      = 4'h0;
   localparam logic [3:0]  NIB_TWO      = 4'h1;
   localparam logic [3:0]  NIB_RD       = 4'h2;
   ////////////////////////////////////////////////////////////////////////////////
   // decode windows
   localparam logic [15:0] IO_LO        = 16'h0200;
   localparam logic [15:0] IO_HI        = 16'h02ff;
   localparam logic [15:0] GLUE_IO_LO   = 16'h02f0;
   localparam logic [15:0] GLUE_IO_HI   = 16'h02ff;
   localparam logic [31:0] MEM_LO       = 32'hfe00_0000;
   localparam logic [31:0] MEM_HI       = 32'hfe00_ffff;
   localparam logic [31:0] GLUE_MEM_LO  = 32'hfe00_f000;
   localparam logic [31:0] GLUE_MEM_HI  = 32'hfe00_ffff;
   localparam logic [3:0]  FW_IDSEL     = 4'h0;
   localparam logic [2:0]  DMA_CH       = 3'h3;
   ////////////////////////////////////////////////////////////////////////////////
   // dma request and serirq framing
   localparam logic [2:0]  DRQ_BITS     = 3'h5;
   localparam int          NUM_SRC      = 4;
   localparam int          NUM_IRQ      = 16;
   localparam logic [4:0]  LAST_SLOT    = 5'h14;
   localparam logic [1:0]  LAST_PHASE   = 2'h2;
   localparam logic [3:0]  START_MIN    = 4'h4;
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      LS_IDLE  = 4'h0, LS_CYC  = 4'h1, LS_ADDR = 4'h2, LS_SIZE  = 4'h3,
      LS_WDATA = 4'h4, LS_TAR  = 4'h5, LS_SYNC = 4'h6, LS_RDATA = 4'h7,
      LS_RTAR  = 4'h8, LS_SKIP = 4'h9
   } lpc_state_t;
   typedef enum logic [1:0] {
      AK_IO = 2'h0, AK_MEM = 2'h1, AK_DMA = 2'h2, AK_FW = 2'h3
   } acc_kind_t;
   typedef enum logic [1:0] {
      SQ_IDLE = 2'h0, SQ_SLOT = 2'h1, SQ_STOP = 2'h2
   } sq_state_t;
endpackage : lpc_irq_pkg
`default_nettype wire

// ==== verilog/lpc_peripheral_irq_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpc_peripheral_irq_serializer (
   input  wire logic                   mclk,
   input  wire logic                   arst_n,
   input  wire logic                   lframe_n,
   input  wire logic [3:0]             lad_in,
   output logic      [3:0]             lad_out,
   output logic                        lad_oe,
   output logic                        ldrq_n,
   input  wire logic                   serirq_in,
   output logic                        serirq_out,
   output logic                        serirq_oe,
   output logic                        acc_req,
   output logic                        acc_write,
   output lpc_irq_pkg::acc_kind_t      acc_kind,
   output logic      [31:0]            acc_addr,
   output logic      [7:0]             acc_wdata,
   input  wire logic                   acc_ack,
   input  wire logic [7:0]             acc_rdata,
   input  wire logic                   dma_req,
   input  wire logic [3:0]             internal_parallel_irq_lines,
   input  wire logic [15:0]            irq_map,
   input  wire logic [3:0]             irq_enable,
   input  wire logic [3:0]             irq_polarity
);
   import lpc_irq_pkg::*;

   lpc_state_t  state;
   acc_kind_t   kind;
   logic        is_write;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic [3:0]  nib;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        claim_io;
   logic        claim_mem;
   logic        claim_size;
   logic        drq_sent;
   logic [2:0]  drq_cnt;
   logic [4:0]  drq_shift;
   sq_state_t   sq_state;
   logic [3:0]  low_run;
   logic [4:0]  slot;
   logic [1:0]  phase;
   logic [4:0]  next_slot;
   logic [1:0]  next_phase;
   logic [15:0] mapped;
   logic [15:0] owned;
   logic [3:0]  win;
   logic        dup;
   logic [15:0] cond;
   logic [15:0] own;
   logic [15:0] sent;
   logic        change;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // address decode, glue windows excluded
   always_comb begin
      next_addr = {addr[27:0], lad_in};
      claim_io  = (next_addr[15:0] >= IO_LO) && (next_addr[15:0] <= IO_HI) &&
                  !((next_addr[15:0] >= GLUE_IO_LO) && (next_addr[15:0] <= GLUE_IO_HI)); // R3
      claim_mem = (next_addr >= MEM_LO) && (next_addr <= MEM_HI) &&
                  !((next_addr >= GLUE_MEM_LO) && (next_addr <= GLUE_MEM_HI)); // R3
      if (kind == AK_DMA) begin
         claim_size = (addr[2:0] == DMA_CH) && (lad_in[1:0] == 2'h0); // R2
      end else begin
         claim_size = (addr[31:28] == FW_IDSEL) && (lad_in == 4'h0); // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // lpc cycle engine
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= LS_IDLE;
         kind      <= AK_IO;
         is_write  <= 1'b0;
         addr      <= 32'h0000_0000;
         nib       <= 4'h0;
         wdata     <= 8'h00;
         rdata     <= 8'h00;
         lad_out   <= LAD_IDLE;
         lad_oe    <= 1'b0;
         acc_req   <= 1'b0;
         acc_write <= 1'b0;
         acc_kind  <= AK_IO;
         acc_addr  <= 32'h0000_0000;
         acc_wdata <= 8'h00;
      end else begin
         acc_req <= 1'b0;
         if (!lframe_n) begin
            lad_oe <= 1'b0;
            addr   <= 32'h0000_0000;
            nib    <= NIB_MEM;
            if (lad_in == START_MEM_IO) begin
               state <= LS_CYC;
            end else if ((lad_in == START_FW_RD) || (lad_in == START_FW_WR)) begin
               state    <= LS_ADDR; // R2
               kind     <= AK_FW;
               is_write <= (lad_in == START_FW_WR);
            end else begin
               state <= LS_SKIP;
            end
         end else begin
            case (state)
               LS_CYC: begin
                  is_write <= lad_in[1];
                  state    <= LS_ADDR;
                  case (lad_in[3:2])
                     2'b00: begin
                        kind <= AK_IO; // R1
                        nib  <= NIB_IO;
                     end
                     2'b01: begin
                        kind <= AK_MEM; // R1
                        nib  <= NIB_MEM;
                     end
                     2'b10: begin
                        kind     <= AK_DMA; // R2
                        is_write <= ~lad_in[1];
                        nib      <= NIB_ONE;
                     end
                     default: state <= LS_SKIP;
                  endcase
               end
               LS_ADDR: begin
                  addr <= next_addr;
                  nib  <= nib - 4'h1;
                  if (nib == 4'h0) begin
                     nib <= NIB_TWO;
                     if ((kind == AK_DMA) || (kind == AK_FW)) begin
                        state <= LS_SIZE;
                     end else if ((kind == AK_IO) ? claim_io : claim_mem) begin
                        state <= is_write ? LS_WDATA : LS_TAR; // R1
                     end else begin
                        state <= LS_SKIP;
                     end
                  end
               end
               LS_SIZE: begin
                  if (claim_size) begin
                     state <= is_write ? LS_WDATA : LS_TAR;
                  end else begin
                     state <= LS_SKIP;
                  end
               end
               LS_WDATA: begin
                  nib <= nib - 4'h1;
                  if (nib == NIB_TWO) begin
                     wdata[3:0] <= lad_in;
                  end else begin
                     wdata[7:4] <= lad_in;
                     nib        <= NIB_TWO;
                     state      <= LS_TAR;
                  end
               end
               LS_TAR: begin
                  nib <= nib - 4'h1;
                  if (nib == 4'h0) begin
                     state     <= LS_SYNC; // R1
                     lad_oe    <= 1'b1;
                     lad_out   <= SYNC_LWAIT;
                     acc_req   <= 1'b1;
                     acc_write <= is_write;
                     acc_kind  <= kind;
                     acc_addr  <= addr;
                     acc_wdata <= wdata;
                  end
               end
               LS_SYNC: begin
                  if (acc_ack) begin
                     rdata   <= acc_rdata;
                     lad_out <= SYNC_READY; // R1
                     nib     <= is_write ? 4'h0 : NIB_RD;
                     state   <= LS_RDATA;
                  end
               end
               LS_RDATA: begin
                  nib <= nib - 4'h1;
                  if (nib == NIB_RD) begin
                     lad_out <= rdata[3:0];
                  end else if (nib == NIB_TWO) begin
                     lad_out <= rdata[7:4];
                  end else begin
                     lad_out <= LAD_IDLE;
                     state   <= LS_RTAR;
                  end
               end
               LS_RTAR: begin
                  lad_oe <= 1'b0;
                  state  <= LS_IDLE;
               end
               default: state <= state;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // dma request encoder: start bit, channel msb first, request level
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ldrq_n    <= 1'b1;
         drq_sent  <= 1'b0;
         drq_cnt   <= 3'h0;
         drq_shift <= 5'h1f;
      end else if (drq_cnt != 3'h0) begin
         ldrq_n    <= drq_shift[4];
         drq_shift <= {drq_shift[3:0], 1'b1};
         drq_cnt   <= drq_cnt - 3'h1;
      end else if (dma_req != drq_sent) begin
         ldrq_n    <= 1'b0; // R2
         drq_sent  <= dma_req;
         drq_shift <= {DMA_CH, dma_req, 1'b1};
         drq_cnt   <= DRQ_BITS;
      end else begin
         ldrq_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mapping, enable and polarity; the first source to claim a number owns it
   always_comb begin
      mapped = 16'h0000;
      owned  = 16'h0000;
      win    = 4'h0;
      dup    = 1'b0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (irq_enable[s] && !owned[irq_map[4*s +: 4]]) begin
            owned[irq_map[4*s +: 4]]  = 1'b1; // R6
            mapped[irq_map[4*s +: 4]] = internal_parallel_irq_lines[s] ^ irq_polarity[s]; // R4
            win[s]                    = 1'b1;
         end
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         for (int j = i + 1; j < NUM_SRC; j++) begin
            if (win[i] && win[j] && (irq_map[4*i +: 4] == irq_map[4*j +: 4])) begin
               dup = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cond <= 16'h0000;
         own  <= 16'h0000;
      end else begin
         cond <= mapped; // R4
         own  <= owned;
      end
   end

   assign change     = |((cond ^ sent) & own);
   assign next_phase = (phase == LAST_PHASE) ? 2'h0 : phase + 2'h1;
   assign next_slot  = (phase == LAST_PHASE) ? slot + 5'h1 : slot;

   ////////////////////////////////////////////////////////////////////////////////
   // serirq frame tracking and slot driver
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sq_state   <= SQ_IDLE;
         low_run    <= 4'h0;
         slot       <= 5'h00;
         phase      <= 2'h0;
         sent       <= 16'h0000;
         serirq_out <= 1'b1;
         serirq_oe  <= 1'b0;
      end else begin
         case (sq_state)
            SQ_IDLE: begin
               serirq_oe  <= 1'b0;
               serirq_out <= 1'b0;
               if (!serirq_in) begin
                  low_run <= (low_run == 4'hf) ? low_run : low_run + 4'h1;
               end else if (low_run >= START_MIN) begin
                  sq_state  <= SQ_SLOT;
                  low_run   <= 4'h0;
                  slot      <= 5'h00;
                  phase     <= 2'h0;
                  serirq_oe <= own[0] & ~cond[0]; // R5
                  sent[0]   <= cond[0]; // R7
               end else begin
                  low_run   <= 4'h0;
                  serirq_oe <= change & ~serirq_oe; // R7
               end
            end
            SQ_SLOT: begin
               phase <= next_phase;
               slot  <= next_slot;
               if ((slot == LAST_SLOT) && (phase == LAST_PHASE)) begin
                  sq_state  <= SQ_STOP;
                  serirq_oe <= 1'b0;
               end else begin
                  case (next_phase)
                     2'h0: begin
                        serirq_out <= 1'b0;
                        serirq_oe  <= 1'b0;
                        if (next_slot < 5'h10) begin
                           serirq_oe <= own[next_slot[3:0]] & ~cond[next_slot[3:0]]; // R5
                           sent[next_slot[3:0]] <= cond[next_slot[3:0]]; // R8
                        end
                     end
                     2'h1: serirq_out <= 1'b1;
                     default: serirq_oe <= 1'b0;
                  endcase
               end
            end
            SQ_STOP: begin
               if (!serirq_in) begin
                  low_run <= 4'h1;
               end else if (low_run != 4'h0) begin
                  low_run  <= 4'h0;
                  sq_state <= SQ_IDLE;
               end
            end
            default: sq_state <= SQ_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_sync_after_tar;
      lframe_n && (state == LS_TAR) && (nib == 4'h0) |=> lad_oe && (lad_out == SYNC_LWAIT) && acc_req;
   endproperty
   a_sync_after_tar: assert property (p_sync_after_tar) else $error("no long wait after tar"); // R1

   property p_ready_then_float;
      lframe_n && (state == LS_SYNC) && acc_ack && is_write
      |=> (lad_out == SYNC_READY) ##1 (lad_out == LAD_IDLE) ##1 !lad_oe;
   endproperty
   a_ready_then_float: assert property (p_ready_then_float) else $error("bad write sync end"); // R1

   property p_glue_hidden;
      acc_req |-> !((acc_kind == AK_IO) && (acc_addr[15:0] >= GLUE_IO_LO)
                    && (acc_addr[15:0] <= GLUE_IO_HI));
   endproperty
   a_glue_hidden: assert property (p_glue_hidden) else $error("glue reached"); // R3

   property p_dma_channel;
      acc_req && (acc_kind == AK_DMA) |-> (acc_addr[2:0] == DMA_CH);
   endproperty
   a_dma_channel: assert property (p_dma_channel) else $error("wrong dma channel"); // R2

   property p_drq_frame;
      $fell(ldrq_n) && (drq_cnt == DRQ_BITS) |=> (ldrq_n == DMA_CH[2]) ##1 (ldrq_n == DMA_CH[1]);
   endproperty
   a_drq_frame: assert property (p_drq_frame) else $error("bad dma request frame"); // R2

   property p_src0_mapped;
      irq_enable[0] |=> own[$past(irq_map[3:0])]
         && (cond[$past(irq_map[3:0])] == ($past(internal_parallel_irq_lines[0]) ^ $past(irq_polarity[0])));
   endproperty
   a_src0_mapped: assert property (p_src0_mapped) else $error("source 0 not conditioned"); // R4

   property p_no_share;
      !dup;
   endproperty
   a_no_share: assert property (p_no_share) else $error("two sources share a number"); // R6

   property p_drive_in_slot;
      (sq_state == SQ_SLOT) && serirq_oe && !serirq_out |-> (phase == 2'h0) && (slot < 5'h10) && own[slot[3:0]];
   endproperty
   a_drive_in_slot: assert property (p_drive_in_slot) else $error("drive outside own slot"); // R5

   property p_slot_level;
      (sq_state == SQ_SLOT) && (phase == 2'h0) && (slot < 5'h10) && own[slot[3:0]]
      |-> (serirq_oe == !sent[slot[3:0]]) ##1 (serirq_out && (serirq_oe == !$past(sent[slot[3:0]])));
   endproperty
   a_slot_level: assert property (p_slot_level) else $error("slot level wrong"); // R8
endmodule : lpc_peripheral_irq_serializer
`default_nettype wire

// ==== tb/lpc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
   input  wire logic       mclk,
   input  wire logic [3:0] lad_out,
   input  wire logic       lad_oe,
   input  wire logic       ldrq_n,
   input  wire logic       serirq_out,
   input  wire logic       serirq_oe,
   output logic            lframe_n,
   output logic      [3:0] lad_in,
   output logic            serirq_in
);
   logic [3:0] host_lad;
   logic       host_oe;
   logic       host_low;
   ////////////////////////////////////////////////////////////////////////////////
   // both wires have pull-ups
   assign lad_in    = host_oe ? host_lad : (lad_oe ? lad_out : 4'hf);
   assign serirq_in = ~(host_low | (serirq_oe & ~serirq_out));
   initial begin
      lframe_n = 1'b1;
      host_lad = 4'hf;
      host_oe  = 1'b0;
      host_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one lpc cycle: start, n nibbles, two tar nibbles, then wait for ready
   task automatic xfer(input logic [3:0] st, input int n, input logic [63:0] nb,
                       input logic rd, output logic ok, output logic [7:0] rdata);
      int k;
      ok = 1'b0;
      rdata = 8'h00;
      @(posedge mclk);
      lframe_n <= 1'b0;
      host_oe  <= 1'b1;
      host_lad <= st;
      for (k = n - 1; k >= -2; k--) begin
         @(posedge mclk);
         lframe_n <= 1'b1;
         host_lad <= (k >= 0) ? nb[4*k +: 4] : 4'hf;
      end
      @(posedge mclk);
      host_oe <= 1'b0;
      for (k = 0; k < 40 && !ok; k++) begin
         @(posedge mclk);
         ok = (lad_oe === 1'b1 && lad_in === 4'h0);
      end
      if (ok && rd) begin
         @(posedge mclk);
         rdata[3:0] = lad_in;
         @(posedge mclk);
         rdata[7:4] = lad_in;
      end
      repeat (3) @(posedge mclk);
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////////
   // dma request frame: channel bits then level
   task automatic get_drq(output logic [3:0] bits, output logic ok);
      int k;
      ok = 1'b0;
      bits = 4'h0;
      for (k = 0; k < 20 && !ok; k++) begin
         @(posedge mclk);
         ok = (ldrq_n === 1'b0);
      end
      for (k = 3; k >= 0; k--) begin
         @(posedge mclk);
         bits[k] = ldrq_n;
      end
   endtask : get_drq
   ////////////////////////////////////////////////////////////////////////////////
   // serirq frame: start pulse, 21 slots of 3 cycles, stop pulse
   task automatic frame(output logic [20:0] seen);
      int k;
      seen = '1;
      @(posedge mclk);
      host_low <= 1'b1;
      repeat (6) @(posedge mclk);
      host_low <= 1'b0;
      @(posedge mclk);
      for (k = 0; k < 63; k++) begin
         @(posedge mclk);
         if (k % 3 == 0) seen[k/3] = serirq_in;
      end
      host_low <= 1'b1;
      repeat (2) @(posedge mclk);
      host_low <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : frame
endmodule : lpc_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lpc_irq_pkg::*;
   logic        mclk, arst_n, lframe_n, lad_oe, ldrq_n, serirq_in, serirq_out;
   logic        serirq_oe, acc_req, acc_write, acc_ack, dma_req, c_wr, pend;
   logic [3:0]  lad_in, lad_out, lines, irq_enable, irq_polarity;
   logic [7:0]  acc_wdata, acc_rdata, c_wdata;
   logic [15:0] irq_map;
   logic [31:0] acc_addr, c_addr;
   acc_kind_t   acc_kind;
   logic [1:0]  c_kind;
   int          n_errors, cmp_count, n_acc, ack_dly, cnt, cycles;

   lpc_peripheral_irq_serializer u_lpc_peripheral_irq_serializer (
      .mclk(mclk), .arst_n(arst_n), .lframe_n(lframe_n), .lad_in(lad_in),
      .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n), .serirq_in(serirq_in),
      .serirq_out(serirq_out), .serirq_oe(serirq_oe), .acc_req(acc_req),
      .acc_write(acc_write), .acc_kind(acc_kind), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
      .dma_req(dma_req), .internal_parallel_irq_lines(lines), .irq_map(irq_map),
      .irq_enable(irq_enable), .irq_polarity(irq_polarity));
   lpc_host_model u_lpc_host_model (
      .mclk(mclk), .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n),
      .serirq_out(serirq_out), .serirq_oe(serirq_oe), .lframe_n(lframe_n),
      .lad_in(lad_in), .serirq_in(serirq_in));
   ////////////////////////////////////////////////////////////////////////////////
   // internal unit: captures each access, answers ack_dly+1 cycles after capture
   always @(posedge mclk) begin
      acc_ack <= 1'b0;
      cycles++;
      if (acc_req === 1'b1) begin
         {c_kind, c_wr, c_addr, c_wdata} <= {acc_kind, acc_write, acc_addr, acc_wdata};
         acc_rdata <= acc_addr[7:0] ^ 8'h3c;
         pend <= 1'b1;
         cnt <= ack_dly;
         n_acc++;
      end else if (pend && cnt != 0) cnt <= cnt - 1;
      else if (pend) begin
         acc_ack <= 1'b1;
         pend <= 1'b0;
      end
      if (cycles == 10000) begin
         n_errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input logic [3:0] st, input int n, input logic [63:0] nb,
                      input logic rd, input logic cl, input logic [1:0] kd,
                      input logic [31:0] ad, input logic [7:0] wd);
      logic       ok;
      logic [7:0] rdat;
      int         na;
      na = n_acc;
      u_lpc_host_model.xfer(st, n, nb, rd, ok, rdat);
      check(ok, cl);
      check(n_acc - na, cl);
      if (cl) begin
         check({c_kind, c_wr}, {kd, ~rd});
         check(c_addr, ad);
         if (rd) check(rdat, ad[7:0] ^ 8'h3c);
         else check(c_wdata, wd);
      end
   endtask : cyc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_io;
      ack_dly = 0;
      cyc(4'h0, 7, {4'h2, 16'h0200, 8'ha5}, 0, 1, AK_IO, 32'h0200, 8'h5a);
      cyc(4'h0, 5, {4'h0, 16'h02ef}, 1, 1, AK_IO, 32'h02ef, 8'h00);
      cyc(4'h0, 7, {4'h2, 16'h02f0, 8'h1e}, 0, 0, AK_IO, 0, 0);
      cyc(4'h0, 5, {4'h0, 16'h01ff}, 1, 0, AK_IO, 0, 0);
      cyc(4'h0, 5, {4'hc, 16'h0200}, 1, 0, AK_IO, 0, 0);
      cyc(4'h5, 5, {4'h0, 16'h0200}, 1, 0, AK_IO, 0, 0);
   endtask : t_io
   task automatic t_mem;
      ack_dly = 5;
      cyc(4'h0, 11, {4'h6, 32'hfe000010, 8'hc9}, 0, 1, AK_MEM, 32'hfe000010, 8'h9c);
      cyc(4'h0, 9, {4'h4, 32'hfe00efff}, 1, 1, AK_MEM, 32'hfe00efff, 8'h00);
      cyc(4'h0, 9, {4'h4, 32'hfe00f000}, 1, 0, AK_MEM, 0, 0);
   endtask : t_mem
   task automatic t_fw_dma;
      ack_dly = 2;
      cyc(4'hd, 9, {4'h0, 28'h0123456, 4'h0}, 1, 1, AK_FW, 32'h00123456, 8'h00);
      cyc(4'he, 11, {4'h0, 28'h00abcde, 4'h0, 8'h21}, 0, 1, AK_FW, 32'h000abcde, 8'h12);
      cyc(4'hd, 9, {4'h0, 28'h0000010, 4'h1}, 1, 0, AK_FW, 0, 0);
      cyc(4'h0, 5, {4'h8, 4'h3, 4'h0, 8'h7e}, 0, 1, AK_DMA, 32'h3, 8'he7);
      cyc(4'h0, 3, {4'ha, 4'h3, 4'h0}, 1, 1, AK_DMA, 32'h3, 8'h00);
      cyc(4'h0, 3, {4'ha, 4'h2, 4'h0}, 1, 0, AK_DMA, 0, 0);
   endtask : t_fw_dma
   task automatic t_drq;
      logic [3:0] bits;
      logic       ok;
      for (int i = 1; i >= 0; i--) begin
         dma_req <= i[0];
         u_lpc_host_model.get_drq(bits, ok);
         check(ok, 1'b1);
         check(bits, {DMA_CH, i[0]});
      end
   endtask : t_drq
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [20:0] exp_frame(input logic [3:0] ln, en, pl,
                                             input logic [15:0] mp);
      logic [20:0] w;
      w = '1;
      for (int s = 3; s >= 0; s--) begin
         if (en[s]) w[mp[4*s +: 4]] = ln[s] ^ pl[s];
      end
      return w;
   endfunction : exp_frame
   task automatic t_irq;
      logic [11:0] tbl [6];
      logic [20:0] seen;
      tbl = '{12'hff2, 12'hff2, 12'h4f2, 12'hbf2, 12'h070, 12'h0ff};
      irq_map <= 16'h9353;
      for (int i = 0; i < 6; i++) begin
         {lines, irq_enable, irq_polarity} <= tbl[i];
         repeat (8) @(posedge mclk);
         u_lpc_host_model.frame(seen);
         check(seen, exp_frame(tbl[i][11:8], tbl[i][7:4], tbl[i][3:0], 16'h9353));
      end
   endtask : t_irq
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      {n_errors, cmp_count, n_acc, ack_dly, cnt, cycles} = '0;
      {arst_n, dma_req, acc_ack, pend, acc_rdata} = '0;
      {lines, irq_map, irq_enable, irq_polarity} = '0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_io();
      t_mem();
      t_fw_dma();
      t_drq();
      t_irq();
      finish_test();
   end
endmodule : testbench
`default_nettype wire
